// *** rtl/fcid_pkg.sv ***
// Constants, field layouts and helpers for the FP and cache identification bank
package fcid_pkg;

  // Word addresses of the identification words
  localparam logic [31:0] FCID_ADDR_LEVEL_INFO  = 32'hF000FD80;
  localparam logic [31:0] FCID_ADDR_SIZE_INFO   = 32'hF000FD84;
  localparam logic [31:0] FCID_ADDR_FP_WORD0    = 32'hF000FD90;
  localparam logic [31:0] FCID_ADDR_FP_WORD1    = 32'hF000FD94;
  localparam logic [31:0] FCID_ADDR_FP_WORD2    = 32'hF000FD98;

  // Read data shown after reset and on an unmapped or unimplemented access
  localparam logic [31:0] FCID_RDATA_RESET      = 32'h00000000;
  localparam logic [31:0] FCID_UNKNOWN_VALUE    = 32'h00000000;

  // Feature word 0 field positions (low bit of each 4-bit field)
  localparam int FCID_F0_ROUND_LSB    = 28;
  localparam int FCID_F0_SHORTVEC_LSB = 24;
  localparam int FCID_F0_SQRT_LSB     = 20;
  localparam int FCID_F0_DIVIDE_LSB   = 16;
  localparam int FCID_F0_TRAP_LSB     = 12;
  localparam int FCID_F0_DOUBLE_LSB   = 8;
  localparam int FCID_F0_SINGLE_LSB   = 4;
  localparam int FCID_F0_BANK_LSB     = 0;

  // Feature word 1 field positions
  localparam int FCID_F1_FMAC_LSB     = 28;
  localparam int FCID_F1_HALF_LSB     = 24;
  localparam int FCID_F1_RSVD_LSB     = 8;
  localparam int FCID_F1_RSVD_W       = 16;
  localparam int FCID_F1_NAN_PROP_LSB = 4;
  localparam int FCID_F1_FLUSH_LSB    = 0;

  // Feature word 2 field positions
  localparam int FCID_F2_MISC_LSB     = 4;

  // Feature field encodings
  localparam logic [3:0] FCID_FLD_NONE        = 4'h0;
  localparam logic [3:0] FCID_FLD_ONE         = 4'h1;
  localparam logic [3:0] FCID_FLD_TWO         = 4'h2;
  localparam logic [3:0] FCID_FLD_MISC_FULL   = 4'h4;

  // Cache level word field positions
  localparam int FCID_LV_UNIPROC_LSB  = 27;
  localparam int FCID_LV_COHER_LSB    = 24;
  localparam int FCID_LV_INNER_LSB    = 21;
  localparam int FCID_LV_CTYPE_W      = 3;
  localparam int FCID_LV_LEVELS       = 7;

  // Cache type encodings
  localparam logic [2:0] FCID_CTYPE_NONE      = 3'h0;
  localparam logic [2:0] FCID_CTYPE_INSTR     = 3'h1;
  localparam logic [2:0] FCID_CTYPE_DATA      = 3'h2;
  localparam logic [2:0] FCID_CTYPE_SPLIT     = 3'h3;
  localparam logic [2:0] FCID_CTYPE_UNIFIED   = 3'h4;

  // Implemented hierarchy: split level 1, unified level 2
  localparam logic [2:0] FCID_CTYPE_L1        = FCID_CTYPE_SPLIT;
  localparam logic [2:0] FCID_CTYPE_L2        = FCID_CTYPE_UNIFIED;
  localparam logic [2:0] FCID_LEVEL_UNIPROC   = 3'h1;
  localparam logic [2:0] FCID_LEVEL_COHER     = 3'h2;
  localparam logic [2:0] FCID_LEVEL_INNER     = 3'h0;

  // Cache size word field positions
  localparam int FCID_SZ_WR_THRU_BIT  = 31;
  localparam int FCID_SZ_WR_BACK_BIT  = 30;
  localparam int FCID_SZ_RD_ALLOC_BIT = 29;
  localparam int FCID_SZ_WR_ALLOC_BIT = 28;
  localparam int FCID_SZ_SETS_LSB     = 13;
  localparam int FCID_SZ_ASSOC_LSB    = 3;
  localparam int FCID_SZ_LINE_LSB     = 0;

  // Selection layout: level in bits 3:1, instruction-not-data in bit 0
  localparam int FCID_SEL_LEVEL_LSB   = 1;
  localparam int FCID_SEL_INSTR_BIT   = 0;
  localparam int FCID_SEL_ENTRIES     = 14;

  // Packs one cache size word from its fields
  function automatic logic [31:0] fcid_size_word(input logic        wr_thru,
                                                 input logic        wr_back,
                                                 input logic        rd_alloc,
                                                 input logic        wr_alloc,
                                                 input logic [14:0] sets_m1,
                                                 input logic [9:0]  assoc_m1,
                                                 input logic [2:0]  line_code);
    fcid_size_word = {wr_thru, wr_back, rd_alloc, wr_alloc, sets_m1, assoc_m1, line_code};
  endfunction : fcid_size_word

  // Per-cache size words: sets-1, ways-1, line code
  localparam logic [31:0] FCID_SIZE_L1_DATA  =
    fcid_size_word(1'b1, 1'b1, 1'b1, 1'b1, 15'h007F, 10'h003, 3'h1);
  localparam logic [31:0] FCID_SIZE_L1_INSTR =
    fcid_size_word(1'b0, 1'b0, 1'b1, 1'b0, 15'h00FF, 10'h001, 3'h1);
  localparam logic [31:0] FCID_SIZE_L2_UNIF  =
    fcid_size_word(1'b1, 1'b1, 1'b1, 1'b1, 15'h02FF, 10'h007, 3'h2);

endpackage : fcid_pkg

// *** rtl/fcid_size_if.sv ***
// Carrier between the register bank and its cache size table
`timescale 1ns/1ps
interface fcid_size_if;
  logic [2:0]  level;
  logic        instr;
  logic [31:0] word;
  logic        hit;

  modport table_end (input level, input instr, output word, output hit);
  modport bank_end  (output level, output instr, input word, input hit);
endinterface : fcid_size_if

// *** rtl/fcid_size_table.sv ***
// Cache size word table, one entry per level and cache kind
`timescale 1ns/1ps
module fcid_size_table
  import fcid_pkg::*;
(
  fcid_size_if.table_end sz
);

  logic [31:0]              size_words [FCID_SEL_ENTRIES];
  logic [FCID_SEL_ENTRIES-1:0] present;
  logic [3:0]               index;

  // Entry index is the selection value itself
  assign index = {sz.level, sz.instr};

  always_comb
  begin
    for (int i = 0; i < FCID_SEL_ENTRIES; i++)
    begin
      size_words[i] = FCID_UNKNOWN_VALUE;
    end
    present    = '0;
    size_words[0] = FCID_SIZE_L1_DATA;
    size_words[1] = FCID_SIZE_L1_INSTR;
    size_words[2] = FCID_SIZE_L2_UNIF;
    present[0] = 1'b1;
    present[1] = 1'b1;
    present[2] = 1'b1;
  end

  // Unimplemented caches (and level 8 codes) read a fixed filler
  assign sz.hit  = (index < 4'(FCID_SEL_ENTRIES)) ? present[index] : 1'b0;
  assign sz.word = sz.hit ? size_words[index] : FCID_UNKNOWN_VALUE;

endmodule : fcid_size_table

// *** rtl/fcid_bank.sv ***
// Read-only FP feature and cache identification register bank
`timescale 1ns/1ps
// Notes on behaviour
// - Feature word 0 bits 31:28 read 1, all rounding modes.
// - Feature word 0 short vectors and trapping fields read 0.
// - Feature word 0 square root and divide fields read 1.
// - Feature word 0 double field reads 0 absent, 2 present.
// - Feature word 0 single field reads 2.
// - Feature word 0 bank field reads 1, sixteen 64-bit registers.
// - Feature word 1 bits 31:28 read 1, fused multiply-accumulate.
// - Feature word 1 half field reads 1, or 2 with half/double.
// - Feature word 1 bits 23:8 read zero.
// - Feature word 1 NaN field reads 1, NaN propagation.
// - Feature word 1 flush field reads 1, full denormal arithmetic.
// - Feature word 2 misc field reads 0 or 4; rest reserved.
// - Level word top two bits reserved; unification and coherency levels below.
// - Level word inner shareable field reads zero.
// - Seven 3-bit cache type fields from bit 0 upward.
// - Level word is a fixed 32-bit read-only value.
// - One size word per cache, chosen by the selection.
// - Size word bits 31..28 flag write-through, write-back, allocations.
// - Size word bits 27:13 hold sets minus one.
// - Size word bits 12:3 hold associativity minus one.
// - Size word bits 2:0 hold log2 words per line minus two.
// - Selected size word reads at its fixed address; unimplemented reads filler.
module fcid_bank
  import fcid_pkg::*;
#(
  parameter bit DOUBLE_PRESENT = 1'b1,
  parameter bit HALF_TO_DOUBLE = 1'b1,
  parameter bit MISC_PRESENT   = 1'b1
)
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        acc_valid_in,
  input  wire logic        acc_write_in,
  input  wire logic [31:0] acc_addr_in,
  input  wire logic [3:0]  cache_size_select_in,
  output logic             acc_ack_out,
  output logic             acc_err_out,
  output logic             acc_wr_ignored_out,
  output logic [31:0]      acc_rdata_out,
  output logic             size_sel_hit_out
);

  fcid_size_if sz ();

  // Feature word 0 fields
  wire logic [3:0] f0_round;
  wire logic [3:0] f0_shortvec;
  wire logic [3:0] f0_sqrt;
  wire logic [3:0] f0_divide;
  wire logic [3:0] f0_trap;
  wire logic [3:0] f0_double;
  wire logic [3:0] f0_single;
  wire logic [3:0] fp_bank_size_field;
  wire logic [31:0] fp_feature_word0;

  assign f0_round           = FCID_FLD_ONE;
  assign f0_shortvec        = FCID_FLD_NONE;
  assign f0_trap            = FCID_FLD_NONE;
  assign f0_sqrt            = FCID_FLD_ONE;
  assign f0_divide          = FCID_FLD_ONE;
  assign f0_double          = DOUBLE_PRESENT ? FCID_FLD_TWO : FCID_FLD_NONE;
  assign f0_single          = FCID_FLD_TWO;
  assign fp_bank_size_field = FCID_FLD_ONE;

  assign fp_feature_word0 = (32'(f0_round)           << FCID_F0_ROUND_LSB)
                          | (32'(f0_shortvec)        << FCID_F0_SHORTVEC_LSB)
                          | (32'(f0_sqrt)            << FCID_F0_SQRT_LSB)
                          | (32'(f0_divide)          << FCID_F0_DIVIDE_LSB)
                          | (32'(f0_trap)            << FCID_F0_TRAP_LSB)
                          | (32'(f0_double)          << FCID_F0_DOUBLE_LSB)
                          | (32'(f0_single)          << FCID_F0_SINGLE_LSB)
                          | (32'(fp_bank_size_field) << FCID_F0_BANK_LSB);

  // Feature word 1 fields
  wire logic [3:0]  f1_fmac;
  wire logic [3:0]  half_precision_field;
  wire logic [15:0] f1_reserved;
  wire logic [3:0]  default_nan_field;
  wire logic [3:0]  flush_zero_field;
  wire logic [31:0] fp_feature_word1;

  assign f1_fmac              = FCID_FLD_ONE;
  // Half/double conversion needs double precision hardware
  assign half_precision_field = (HALF_TO_DOUBLE && DOUBLE_PRESENT) ?
                                FCID_FLD_TWO : FCID_FLD_ONE;
  assign f1_reserved          = '0;
  assign default_nan_field    = FCID_FLD_ONE;
  assign flush_zero_field     = FCID_FLD_ONE;

  assign fp_feature_word1 = (32'(f1_fmac)              << FCID_F1_FMAC_LSB)
                          | (32'(half_precision_field) << FCID_F1_HALF_LSB)
                          | (32'(f1_reserved)          << FCID_F1_RSVD_LSB)
                          | (32'(default_nan_field)    << FCID_F1_NAN_PROP_LSB)
                          | (32'(flush_zero_field)     << FCID_F1_FLUSH_LSB);

  // Feature word 2: only the misc field, reserved bits read zero
  wire logic [3:0]  fp_misc_field;
  wire logic [31:0] fp_feature_word2;

  assign fp_misc_field    = MISC_PRESENT ? FCID_FLD_MISC_FULL : FCID_FLD_NONE;
  assign fp_feature_word2 = 32'(fp_misc_field) << FCID_F2_MISC_LSB;

  // Cache level word
  wire logic [2:0]  unify_level_uniproc;
  wire logic [2:0]  coherency_level;
  wire logic [2:0]  unify_level_inner_share;
  wire logic [2:0]  ctype [FCID_LV_LEVELS];
  wire logic [20:0] ctype_bits;
  wire logic [31:0] cache_level_info;

  assign unify_level_uniproc     = FCID_LEVEL_UNIPROC;
  assign coherency_level         = FCID_LEVEL_COHER;
  assign unify_level_inner_share = FCID_LEVEL_INNER;

  // Level 1 split, level 2 unified, the rest none so a scan stops at 3
  assign ctype[0] = FCID_CTYPE_L1;
  assign ctype[1] = FCID_CTYPE_L2;
  assign ctype[2] = FCID_CTYPE_NONE;
  assign ctype[3] = FCID_CTYPE_NONE;
  assign ctype[4] = FCID_CTYPE_NONE;
  assign ctype[5] = FCID_CTYPE_NONE;
  assign ctype[6] = FCID_CTYPE_NONE;

  // A level counts only if it and every level below it hold a legal cache code
  wire logic [FCID_LV_LEVELS-1:0] level_open;
  wire logic [2:0]                ctype_shown [FCID_LV_LEVELS];

  genvar gl;
  generate
    for (gl = 0; gl < FCID_LV_LEVELS; gl++)
    begin : g_ctype
      wire logic code_ok;

      assign code_ok = (ctype[gl] != FCID_CTYPE_NONE) & (ctype[gl] <= FCID_CTYPE_UNIFIED);
      if (gl == 0)
      begin : g_first
        assign level_open[gl] = code_ok;
      end
      else
      begin : g_upper
        assign level_open[gl] = level_open[gl-1] & code_ok;
      end
      // Reserved codes and levels past the first gap read as none
      assign ctype_shown[gl] = level_open[gl] ? ctype[gl] : FCID_CTYPE_NONE;
      assign ctype_bits[gl*FCID_LV_CTYPE_W +: FCID_LV_CTYPE_W] = ctype_shown[gl];
    end
  endgenerate

  // Levels in use; the reported levels never point past the hierarchy
  logic [2:0]       levels_used;
  wire logic [2:0]  uniproc_shown;
  wire logic [2:0]  coher_shown;

  always_comb
  begin
    levels_used = 3'h0;
    for (int i = 0; i < FCID_LV_LEVELS; i++)
    begin
      levels_used = levels_used + 3'(level_open[i]);
    end
  end

  assign uniproc_shown = (unify_level_uniproc > levels_used) ? levels_used :
                         unify_level_uniproc;
  assign coher_shown   = (coherency_level > levels_used) ? levels_used :
                         coherency_level;

  // Bits 31:30 are unknown by definition; this bank drives zero there
  assign cache_level_info = (32'(uniproc_shown)           << FCID_LV_UNIPROC_LSB)
                          | (32'(coher_shown)             << FCID_LV_COHER_LSB)
                          | (32'(unify_level_inner_share) << FCID_LV_INNER_LSB)
                          | 32'(ctype_bits);

  // Cache size lookup from the live selection
  wire logic [31:0] size_word;
  wire logic        size_hit;
  wire logic        write_through_flag;
  wire logic        write_back_flag;
  wire logic        read_allocate_flag;
  wire logic        write_allocate_flag;
  wire logic [14:0] set_count_minus_one;
  wire logic [9:0]  ways_minus_one;
  wire logic [2:0]  line_length_code;
  wire logic [31:0] cache_size_info;

  assign sz.level = cache_size_select_in[FCID_SEL_LEVEL_LSB +: 3];
  assign sz.instr = cache_size_select_in[FCID_SEL_INSTR_BIT];
  assign size_word = sz.word;
  assign size_hit  = sz.hit;

  fcid_size_table u_size_table (
    .sz (sz.table_end)
  );

  assign write_through_flag  = size_word[FCID_SZ_WR_THRU_BIT];
  assign write_back_flag     = size_word[FCID_SZ_WR_BACK_BIT];
  assign read_allocate_flag  = size_word[FCID_SZ_RD_ALLOC_BIT];
  assign write_allocate_flag = size_word[FCID_SZ_WR_ALLOC_BIT];
  assign set_count_minus_one = size_word[FCID_SZ_SETS_LSB +: 15];
  assign ways_minus_one      = size_word[FCID_SZ_ASSOC_LSB +: 10];
  assign line_length_code    = size_word[FCID_SZ_LINE_LSB +: 3];

  assign cache_size_info = {write_through_flag, write_back_flag,
                            read_allocate_flag, write_allocate_flag,
                            set_count_minus_one, ways_minus_one,
                            line_length_code};

  // Address decode
  wire logic hit_fp0;
  wire logic hit_fp1;
  wire logic hit_fp2;
  wire logic hit_level;
  wire logic hit_size;
  wire logic hit_any;

  assign hit_fp0   = (acc_addr_in == FCID_ADDR_FP_WORD0);
  assign hit_fp1   = (acc_addr_in == FCID_ADDR_FP_WORD1);
  assign hit_fp2   = (acc_addr_in == FCID_ADDR_FP_WORD2);
  assign hit_level = (acc_addr_in == FCID_ADDR_LEVEL_INFO);
  assign hit_size  = (acc_addr_in == FCID_ADDR_SIZE_INFO);
  assign hit_any   = hit_fp0 | hit_fp1 | hit_fp2 | hit_level | hit_size;

  // Read selection
  wire logic [31:0] read_word;
  wire logic [31:0] pick_fp0;
  wire logic [31:0] pick_fp1;
  wire logic [31:0] pick_fp2;
  wire logic [31:0] pick_level;
  wire logic [31:0] pick_size;
  wire logic        do_read;
  wire logic        do_write;
  wire logic        acc_miss;
  wire logic        wr_mapped;

  // One-hot decode lets every word be gated and merged
  assign pick_fp0   = {32{hit_fp0}}   & fp_feature_word0;
  assign pick_fp1   = {32{hit_fp1}}   & fp_feature_word1;
  assign pick_fp2   = {32{hit_fp2}}   & fp_feature_word2;
  assign pick_level = {32{hit_level}} & cache_level_info;
  assign pick_size  = {32{hit_size}}  & cache_size_info;
  assign read_word  = hit_any ? (pick_fp0 | pick_fp1 | pick_fp2 | pick_level | pick_size)
                              : FCID_UNKNOWN_VALUE;

  assign do_read  = acc_valid_in & ~acc_write_in;
  assign do_write = acc_valid_in &  acc_write_in;
  assign acc_miss  = acc_valid_in & ~hit_any;
  assign wr_mapped = do_write & hit_any;

  // Response registers
  logic        ack_q;
  logic        ack_d;
  logic        err_q;
  logic        err_d;
  logic        wr_ign_q;
  logic        wr_ign_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        sel_hit_q;
  logic        sel_hit_d;

  assign ack_d     = acc_valid_in;
  assign err_d     = acc_miss;
  // Writes change nothing; a mapped write is simply flagged
  assign wr_ign_d  = wr_mapped;
  // Read data holds across writes and idle cycles
  assign rdata_d   = do_read ? read_word : rdata_q;
  assign sel_hit_d = size_hit;

  // One short register per output
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      err_q <= 1'b0;
    end
    else
    begin
      err_q <= err_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ign_q <= 1'b0;
    end
    else
    begin
      wr_ign_q <= wr_ign_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_q <= FCID_RDATA_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sel_hit_q <= 1'b0;
    end
    else
    begin
      sel_hit_q <= sel_hit_d;
    end
  end

  assign acc_ack_out        = ack_q;
  assign acc_err_out        = err_q;
  assign acc_wr_ignored_out = wr_ign_q;
  assign acc_rdata_out      = rdata_q;
  assign size_sel_hit_out   = sel_hit_q;

endmodule : fcid_bank

// *** test/fcid_bank_assertions.sv ***
// Port-level checks for the identification register bank
`timescale 1ns/1ps
module fcid_bank_assertions
  import fcid_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        acc_valid_in,
  input wire logic        acc_write_in,
  input wire logic [31:0] acc_addr_in,
  input wire logic [3:0]  cache_size_select_in,
  input wire logic        acc_ack_out,
  input wire logic        acc_err_out,
  input wire logic        acc_wr_ignored_out,
  input wire logic [31:0] acc_rdata_out,
  input wire logic        size_sel_hit_out
);
  wire logic rd_w;
  wire logic map_w;
  wire logic size_w;

  assign rd_w   = acc_valid_in && !acc_write_in;
  assign size_w = rd_w && (acc_addr_in == FCID_ADDR_SIZE_INFO);
  assign map_w  = (acc_addr_in == FCID_ADDR_LEVEL_INFO) || (acc_addr_in == FCID_ADDR_SIZE_INFO)
               || (acc_addr_in == FCID_ADDR_FP_WORD0) || (acc_addr_in == FCID_ADDR_FP_WORD1)
               || (acc_addr_in == FCID_ADDR_FP_WORD2);

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  req_gets_ack_a: assert property (acc_valid_in |=> acc_ack_out)
    else $error("request not acknowledged");
  idle_quiet_a: assert property (!acc_valid_in |=> !acc_ack_out && !acc_wr_ignored_out)
    else $error("response without request");
  fp_word0_a: assert property (rd_w && acc_addr_in == FCID_ADDR_FP_WORD0
    |=> acc_rdata_out == 32'h10110221) else $error("feature word 0 value");
  fp_word1_a: assert property (rd_w && acc_addr_in == FCID_ADDR_FP_WORD1
    |=> acc_rdata_out == 32'h12000011) else $error("feature word 1 value");
  fp_word2_a: assert property (rd_w && acc_addr_in == FCID_ADDR_FP_WORD2
    |=> acc_rdata_out[7:4] == 4'h4) else $error("feature word 2 value");
  level_word_a: assert property (rd_w && acc_addr_in == FCID_ADDR_LEVEL_INFO
    |=> acc_rdata_out[29:0] == 30'h0A000023) else $error("level word value");
  size_data_a: assert property (size_w && cache_size_select_in == 4'h0
    |=> acc_rdata_out == 32'hF00FE019) else $error("data cache size word");
  size_instr_a: assert property (size_w && cache_size_select_in == 4'h1
    |=> acc_rdata_out == 32'h201FE009) else $error("instruction cache size word");
  size_unified_a: assert property (size_w && cache_size_select_in == 4'h2
    |=> acc_rdata_out == 32'hF05FE03A) else $error("unified cache size word");
  size_none_a: assert property (size_w && cache_size_select_in > 4'h2
    |=> acc_rdata_out == 32'h0 && !acc_err_out) else $error("unimplemented size word");
  write_flag_a: assert property (acc_valid_in && acc_write_in && map_w
    |=> acc_wr_ignored_out && !acc_err_out) else $error("write not flagged ignored");
  unmapped_err_a: assert property (acc_valid_in && !map_w
    |=> acc_err_out && !acc_wr_ignored_out) else $error("unmapped access not flagged");
  sel_hit_a: assert property (rst_n_in
    |=> size_sel_hit_out == ($past(cache_size_select_in) < 4'h3)) else $error("hit flag");
  rdata_hold_a: assert property (!rd_w |=> $stable(acc_rdata_out))
    else $error("read data changed without a read");
endmodule : fcid_bank_assertions

bind fcid_bank fcid_bank_assertions chk_u (
  .core_clk_in          (core_clk_in),
  .rst_n_in             (rst_n_in),
  .acc_valid_in         (acc_valid_in),
  .acc_write_in         (acc_write_in),
  .acc_addr_in          (acc_addr_in),
  .cache_size_select_in (cache_size_select_in),
  .acc_ack_out          (acc_ack_out),
  .acc_err_out          (acc_err_out),
  .acc_wr_ignored_out   (acc_wr_ignored_out),
  .acc_rdata_out        (acc_rdata_out),
  .size_sel_hit_out     (size_sel_hit_out)
);

// *** test/fcid_bank_tb.sv ***
// Self-checking bench for the identification register bank
`timescale 1ns/1ps
`define CHK(act, exp) \
  begin \
    n_compared++; \
    if ((act) !== (exp)) \
    begin \
      error_cnt++; \
      $display("Error at %0t: got %h expected %h", $time, (act), (exp)); \
    end \
  end
module fcid_bank_tb
  import fcid_pkg::*;
;
  logic        core_clk_in          = 1'b0;
  logic        rst_n_in             = 1'b0;
  logic        acc_valid_in         = 1'b0;
  logic        acc_write_in         = 1'b0;
  logic [31:0] acc_addr_in          = 32'h0;
  logic [3:0]  cache_size_select_in = 4'h0;
  logic        acc_ack_out;
  logic        acc_err_out;
  logic        acc_wr_ignored_out;
  logic [31:0] acc_rdata_out;
  logic        size_sel_hit_out;
  int          error_cnt            = 0;
  int          n_compared           = 0;
  integer      seed                 = 32'hF1AF;
  logic        p_v, p_w, p_map;
  logic [3:0]  p_sel;
  logic [31:0] rd_exp;
  logic [31:0] addr_tab [5] = '{FCID_ADDR_LEVEL_INFO, FCID_ADDR_SIZE_INFO, FCID_ADDR_FP_WORD0,
                                FCID_ADDR_FP_WORD1, FCID_ADDR_FP_WORD2};

  fcid_bank dut_u (
    .core_clk_in          (core_clk_in),
    .rst_n_in             (rst_n_in),
    .acc_valid_in         (acc_valid_in),
    .acc_write_in         (acc_write_in),
    .acc_addr_in          (acc_addr_in),
    .cache_size_select_in (cache_size_select_in),
    .acc_ack_out          (acc_ack_out),
    .acc_err_out          (acc_err_out),
    .acc_wr_ignored_out   (acc_wr_ignored_out),
    .acc_rdata_out        (acc_rdata_out),
    .size_sel_hit_out     (size_sel_hit_out)
  );

  always #25 core_clk_in = ~core_clk_in;

  // Size word per selection, zero where no cache exists
  function automatic logic [31:0] size_exp(input logic [3:0] sel);
    case (sel)
      4'h0: size_exp = {4'hF, 15'h007F, 10'h003, 3'h1};
      4'h1: size_exp = {4'h2, 15'h00FF, 10'h001, 3'h1};
      4'h2: size_exp = {4'hF, 15'h02FF, 10'h007, 3'h2};
      default: size_exp = 32'h0;
    endcase
  endfunction : size_exp

  // Bit 32 marks a mapped address
  function automatic logic [32:0] word_exp(input logic [31:0] a, input logic [3:0] s);
    case (a)
      FCID_ADDR_FP_WORD0: word_exp = {1'b1, 4'h1, 4'h0, 4'h1, 4'h1, 4'h0, 4'h2, 4'h2, 4'h1};
      FCID_ADDR_FP_WORD1: word_exp = {1'b1, 4'h1, 4'h2, 16'h0, 4'h1, 4'h1};
      FCID_ADDR_FP_WORD2: word_exp = {1'b1, 24'h0, 4'h4, 4'h0};
      FCID_ADDR_LEVEL_INFO: word_exp = {1'b1, 2'h0, 3'h1, 3'h2, 3'h0, 15'h0, 3'h4, 3'h3};
      FCID_ADDR_SIZE_INFO: word_exp = {1'b1, size_exp(s)};
      default: word_exp = 33'h0;
    endcase
  endfunction : word_exp

  // Drives one request and checks the answer to the one before it
  task automatic step(input logic v, input logic w, input logic [31:0] a, input logic [3:0] s);
    logic [32:0] e;
    @(posedge core_clk_in);
    acc_valid_in <= v;
    acc_write_in <= w;
    acc_addr_in <= a;
    cache_size_select_in <= s;
    #1;
    `CHK(acc_ack_out, p_v)
    `CHK(acc_err_out, p_v && !p_map)
    `CHK(acc_wr_ignored_out, p_v && p_w && p_map)
    `CHK(acc_rdata_out, rd_exp)
    `CHK(size_sel_hit_out, p_sel < 4'h3)
    e = word_exp(a, s);
    if (v && !w)
      rd_exp = e[31:0];
    p_v = v;
    p_w = w;
    p_map = e[32];
    p_sel = s;
  endtask : step

  task automatic do_reset();
    @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    acc_valid_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    `CHK({acc_ack_out, acc_err_out, acc_wr_ignored_out, size_sel_hit_out, acc_rdata_out}, 36'h0)
    rst_n_in <= 1'b1;
    p_v = 1'b0;
    p_sel = cache_size_select_in;
    rd_exp = 32'h0;
  endtask : do_reset

  task automatic conclude();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    #1000000;
    error_cnt++;
    conclude();
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] a;
    do_reset();
    // Every selection, back to back
    for (int i = 0; i < 16; i++)
      step(1'b1, 1'b0, FCID_ADDR_SIZE_INFO, i[3:0]);
    // Write, read back, neighbour, idle for each word
    foreach (addr_tab[i])
    begin
      step(1'b1, 1'b1, addr_tab[i], 4'h0);
      step(1'b1, 1'b0, addr_tab[i], 4'h1);
      step(1'b1, 1'b0, addr_tab[i] + 32'h8, 4'h2);
      step(1'b0, 1'b1, addr_tab[i], 4'hF);
    end
    step(1'b1, 1'b1, 32'h0, 4'h2);
    do_reset();
    for (int i = 0; i < 600; i++)
    begin
      r = $random(seed);
      a = r[2] ? addr_tab[r[6:4] % 3'h5] : $random(seed);
      step(r[0] | r[1], r[3], a, r[11:8]);
    end
    step(1'b0, 1'b0, 32'h0, 4'h0);
    conclude();
  end
endmodule : fcid_bank_tb
